/* File: verilog/ucpt_params.svh */
// offsets, field positions and reset values of the serial character block
`ifndef UCPT_PARAMS_SVH
`define UCPT_PARAMS_SVH

// register byte offsets
`define UCPT_CMD_OFS 8'h00
`define UCPT_CFG_OFS 8'h04
`define UCPT_STAT_OFS 8'h08
`define UCPT_RHR_OFS 8'h0c
`define UCPT_THR_OFS 8'h10
`define UCPT_IDLE_OFS 8'h14
`define UCPT_GUARD_OFS 8'h18

// command register bits
`define UCPT_CMD_CLR_STATUS 0
`define UCPT_CMD_SEND_ADDR 1
`define UCPT_CMD_ARM_IDLE 2
`define UCPT_CMD_RELOAD_IDLE 3

// line config fields
`define UCPT_CFG_PAR_LSB 0
`define UCPT_CFG_PAR_MSB 2
`define UCPT_CFG_STOP2 3

// status bits
`define UCPT_ST_RX_READY 0
`define UCPT_ST_TX_FREE 1
`define UCPT_ST_OVERRUN 2
`define UCPT_ST_PARITY 3
`define UCPT_ST_TX_DONE 4
`define UCPT_ST_TIMEOUT 5

// reset values
`define UCPT_CFG_RST 4'h4
`define UCPT_IDLE_RST 16'h0000
`define UCPT_GUARD_RST 8'h00

`endif

/* File: verilog/ucpt_pkg.sv */
// types of the serial character block
package ucpt_pkg;

   // parity type field encodings; 3'h5 behaves as none
   typedef enum logic [2:0] {
      PAR_EVEN = 3'h0,
      PAR_ODD = 3'h1,
      PAR_SPACE = 3'h2,
      PAR_MARK = 3'h3,
      PAR_NONE = 3'h4,
      PAR_RSVD = 3'h5,
      PAR_MDROP0 = 3'h6,
      PAR_MDROP1 = 3'h7
   } ucpt_par_t;

   // receive sequencer
   typedef enum logic [1:0] {
      RX_IDLE = 2'h0,
      RX_DATA = 2'h1,
      RX_PAR = 2'h3,
      RX_STOP = 2'h2
   } ucpt_rx_t;

   // transmit sequencer
   typedef enum logic [2:0] {
      TX_IDLE = 3'h0,
      TX_START = 3'h1,
      TX_DATA = 3'h3,
      TX_PAR = 3'h2,
      TX_STOP = 3'h6,
      TX_GUARD = 3'h7
   } ucpt_tx_t;

endpackage

/* File: verilog/ucpt_serial.sv */
// synchronous serial character port with parity, timeguard and idle time-out
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ucpt_params.svh"

module ucpt_serial #(
   parameter int DATA_BITS = 8,
   parameter int IDLE_W = 16,
   parameter int GUARD_W = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial line
   input wire logic bitClk,
   input wire logic rxd,
   output logic txd
);

   ////////////////////////////////////////////////////////////////////////
   // functions

   // parity bit to send for a data word
   function automatic logic parGen(input logic [2:0] mode, input logic [DATA_BITS-1:0] d,
                                   input logic addr);
      unique case (ucpt_pkg::ucpt_par_t'(mode))
         ucpt_pkg::PAR_EVEN: parGen = ^d;
         ucpt_pkg::PAR_ODD: parGen = ~^d;
         ucpt_pkg::PAR_MARK: parGen = 1'b1;
         ucpt_pkg::PAR_MDROP0, ucpt_pkg::PAR_MDROP1: parGen = addr;
         default: parGen = 1'b0;
      endcase
   endfunction

   // true when the received parity bit is to be flagged
   function automatic logic parBad(input logic [2:0] mode, input logic [DATA_BITS-1:0] d,
                                   input logic p);
      unique case (ucpt_pkg::ucpt_par_t'(mode))
         ucpt_pkg::PAR_EVEN: parBad = p != ^d;
         ucpt_pkg::PAR_ODD: parBad = p != ~^d;
         ucpt_pkg::PAR_MARK: parBad = ~p;
         ucpt_pkg::PAR_SPACE: parBad = p;
         ucpt_pkg::PAR_MDROP0, ucpt_pkg::PAR_MDROP1: parBad = p;
         default: parBad = 1'b0;
      endcase
   endfunction

   // true when the mode carries a parity bit in the frame
   function automatic logic parOn(input logic [2:0] mode);
      parOn = !(mode == ucpt_pkg::PAR_NONE || mode == ucpt_pkg::PAR_RSVD);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic [2:0] sckS_q;
   logic sckLvl_q;
   logic sckLvl_d;
   logic [2:0] rxS_q;
   logic rxLvl_q;
   logic bitRise;
   logic bitFall;
   logic [3:0] cfg_q;
   logic [IDLE_W-1:0] idleLim_q;
   logic [GUARD_W-1:0] guard_q;
   logic wrStb;
   logic rdStb;
   logic cmdWr;
   logic clrStatus;
   logic sendAddr;
   logic armIdle;
   logic reloadIdle;
   logic thrWr;
   logic rhrRd;
   logic mapped;
   ucpt_pkg::ucpt_rx_t rxSt_q;
   logic [DATA_BITS-1:0] rxSh_q;
   logic [3:0] rxCnt_q;
   logic rxParBad_q;
   logic rxDone;
   logic [DATA_BITS-1:0] rhr_q;
   logic rxReady_q;
   logic overrun_q;
   logic parErr_q;
   ucpt_pkg::ucpt_tx_t txSt_q;
   logic [DATA_BITS-1:0] thr_q;
   logic thrAddr_q;
   logic thrFull_q;
   logic addrPend_q;
   logic [DATA_BITS-1:0] txSh_q;
   logic txPar_q;
   logic [3:0] txCnt_q;
   logic [GUARD_W-1:0] gCnt_q;
   logic txLoad;
   logic [IDLE_W-1:0] idleCnt_q;
   logic idleRun_q;
   logic timeout_q;
   logic idleHit;
   logic [31:0] rdMux;

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers: a level counts once stages two and three agree

   always_comb begin
      sckLvl_d = (sckS_q[1] == sckS_q[2]) ? sckS_q[2] : sckLvl_q;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sckS_q <= 3'h0;
         sckLvl_q <= 1'b0;
         rxS_q <= 3'h7;
         rxLvl_q <= 1'b1;
      end else begin
         sckS_q <= {sckS_q[1:0], bitClk};
         sckLvl_q <= sckLvl_d;
         rxS_q <= {rxS_q[1:0], rxd};
         if (rxS_q[1] == rxS_q[2]) begin
            rxLvl_q <= rxS_q[2];
         end
      end
   end

   assign bitRise = sckLvl_d & ~sckLvl_q;
   assign bitFall = ~sckLvl_d & sckLvl_q;

   ////////////////////////////////////////////////////////////////////////
   // apb decode: zero wait states, unmapped offsets answer pslverr

   assign wrStb = psel & penable & pwrite;
   assign rdStb = psel & penable & ~pwrite;
   assign cmdWr = wrStb && paddr == `UCPT_CMD_OFS;
   assign clrStatus = cmdWr & pwdata[`UCPT_CMD_CLR_STATUS];
   assign sendAddr = cmdWr & pwdata[`UCPT_CMD_SEND_ADDR];
   assign armIdle = cmdWr & pwdata[`UCPT_CMD_ARM_IDLE];
   assign reloadIdle = cmdWr & pwdata[`UCPT_CMD_RELOAD_IDLE];
   assign thrWr = wrStb && paddr == `UCPT_THR_OFS;
   assign rhrRd = rdStb && paddr == `UCPT_RHR_OFS;
   assign pready = 1'b1;

   // offset map check
   always_comb begin
      unique case (paddr)
         `UCPT_CMD_OFS, `UCPT_CFG_OFS, `UCPT_STAT_OFS, `UCPT_RHR_OFS,
         `UCPT_THR_OFS, `UCPT_IDLE_OFS, `UCPT_GUARD_OFS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   assign pslverr = psel & penable & ~mapped;

   // read data selection
   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (paddr)
         `UCPT_CFG_OFS: rdMux[3:0] = cfg_q;
         `UCPT_STAT_OFS: begin
            rdMux[`UCPT_ST_RX_READY] = rxReady_q;
            rdMux[`UCPT_ST_TX_FREE] = ~thrFull_q;
            rdMux[`UCPT_ST_OVERRUN] = overrun_q;
            rdMux[`UCPT_ST_PARITY] = parErr_q;
            rdMux[`UCPT_ST_TX_DONE] = ~thrFull_q && txSt_q == ucpt_pkg::TX_IDLE;
            rdMux[`UCPT_ST_TIMEOUT] = timeout_q;
         end
         `UCPT_RHR_OFS: rdMux[DATA_BITS-1:0] = rhr_q;
         `UCPT_IDLE_OFS: rdMux[IDLE_W-1:0] = idleLim_q;
         `UCPT_GUARD_OFS: rdMux[GUARD_W-1:0] = guard_q;
         default: rdMux = 32'h0000_0000;
      endcase
   end

   // read data captured in the setup cycle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rdMux;
      end
   end

   // configuration registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cfg_q <= `UCPT_CFG_RST;
         idleLim_q <= `UCPT_IDLE_RST;
         guard_q <= `UCPT_GUARD_RST;
      end else if (wrStb) begin
         if (paddr == `UCPT_CFG_OFS) begin
            cfg_q <= pwdata[3:0];
         end
         if (paddr == `UCPT_IDLE_OFS) begin
            idleLim_q <= pwdata[IDLE_W-1:0];
         end
         if (paddr == `UCPT_GUARD_OFS) begin
            guard_q <= pwdata[GUARD_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receiver: lsb first, one stop bit whose level is not checked

   assign rxDone = bitRise && rxSt_q == ucpt_pkg::RX_STOP;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rxSt_q <= ucpt_pkg::RX_IDLE;
         rxSh_q <= '0;
         rxCnt_q <= 4'h0;
         rxParBad_q <= 1'b0;
      end else if (bitRise) begin
         unique case (rxSt_q)
            ucpt_pkg::RX_IDLE: begin
               if (!rxLvl_q) begin
                  rxSt_q <= ucpt_pkg::RX_DATA;
                  rxCnt_q <= 4'h0;
                  rxParBad_q <= 1'b0;
               end
            end
            ucpt_pkg::RX_DATA: begin
               rxSh_q <= {rxLvl_q, rxSh_q[DATA_BITS-1:1]};
               rxCnt_q <= rxCnt_q + 4'h1;
               if (rxCnt_q == 4'(DATA_BITS - 1)) begin
                  rxSt_q <= parOn(cfg_q[2:0]) ? ucpt_pkg::RX_PAR : ucpt_pkg::RX_STOP;
               end
            end
            ucpt_pkg::RX_PAR: begin
               rxParBad_q <= parBad(cfg_q[2:0], rxSh_q, rxLvl_q);
               rxSt_q <= ucpt_pkg::RX_STOP;
            end
            ucpt_pkg::RX_STOP: rxSt_q <= ucpt_pkg::RX_IDLE;
         endcase
      end
   end

   // holding register and receive status; a new event wins over a clear
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rhr_q <= '0;
         rxReady_q <= 1'b0;
         overrun_q <= 1'b0;
         parErr_q <= 1'b0;
      end else begin
         if (rxDone) begin
            rhr_q <= rxSh_q;
            rxReady_q <= 1'b1;
         end else if (rhrRd) begin
            rxReady_q <= 1'b0;
         end
         if (rxDone && rxReady_q && !rhrRd) begin
            overrun_q <= 1'b1;
         end else if (clrStatus) begin
            overrun_q <= 1'b0;
         end
         if (rxDone && rxParBad_q) begin
            parErr_q <= 1'b1;
         end else if (clrStatus) begin
            parErr_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // idle time-out counter, one step per bit period

   assign idleHit = idleRun_q && bitRise && idleCnt_q == IDLE_W'(1);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         idleCnt_q <= '0;
         idleRun_q <= 1'b0;
      end else if (idleLim_q == '0) begin
         idleRun_q <= 1'b0;
         idleCnt_q <= '0;
      end else if (rxDone || reloadIdle) begin
         idleCnt_q <= idleLim_q;
         idleRun_q <= 1'b1;
      end else if (armIdle) begin
         idleRun_q <= 1'b0;
      end else if (idleRun_q && bitRise) begin
         idleCnt_q <= idleCnt_q - IDLE_W'(1);
         if (idleHit) begin
            idleRun_q <= 1'b0;
         end
      end
   end

   // time-out flag, cleared by either time-out command; a hit in the same cycle wins
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         timeout_q <= 1'b0;
      end else if (idleLim_q == '0) begin
         timeout_q <= 1'b0;
      end else if (idleHit && !rxDone) begin
         timeout_q <= 1'b1;
      end else if (armIdle || reloadIdle) begin
         timeout_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit holding register and address marking

   assign txLoad = bitFall && thrFull_q && (txSt_q == ucpt_pkg::TX_IDLE
                   || (txSt_q == ucpt_pkg::TX_STOP && txCnt_q == 4'h0 && guard_q == '0)
                   || (txSt_q == ucpt_pkg::TX_GUARD && gCnt_q == GUARD_W'(1)));

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         thr_q <= '0;
         thrAddr_q <= 1'b0;
         thrFull_q <= 1'b0;
         addrPend_q <= 1'b0;
      end else begin
         if (thrWr && !thrFull_q) begin
            thr_q <= pwdata[DATA_BITS-1:0];
            thrAddr_q <= addrPend_q | sendAddr;
            thrFull_q <= 1'b1;
         end else if (txLoad) begin
            thrFull_q <= 1'b0;
         end
         if (sendAddr) begin
            addrPend_q <= 1'b1;
         end else if (thrWr && !thrFull_q) begin
            addrPend_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmitter: shifts on falling bit clock edges, lsb first

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         txSt_q <= ucpt_pkg::TX_IDLE;
         txSh_q <= '0;
         txPar_q <= 1'b0;
         txCnt_q <= 4'h0;
         gCnt_q <= '0;
         txd <= 1'b1;
      end else if (txLoad) begin
         txSt_q <= ucpt_pkg::TX_START;
         txSh_q <= thr_q;
         txPar_q <= parGen(cfg_q[2:0], thr_q, thrAddr_q);
         txCnt_q <= 4'h0;
         txd <= 1'b0;
      end else if (bitFall) begin
         unique case (txSt_q)
            ucpt_pkg::TX_IDLE: txd <= 1'b1;
            ucpt_pkg::TX_START: begin
               txSt_q <= ucpt_pkg::TX_DATA;
               txd <= txSh_q[0];
               txSh_q <= txSh_q >> 1;
               txCnt_q <= 4'h1;
            end
            ucpt_pkg::TX_DATA: begin
               if (txCnt_q == 4'(DATA_BITS)) begin
                  if (parOn(cfg_q[2:0])) begin
                     txSt_q <= ucpt_pkg::TX_PAR;
                     txd <= txPar_q;
                  end else begin
                     txSt_q <= ucpt_pkg::TX_STOP;
                     txd <= 1'b1;
                     txCnt_q <= {3'h0, cfg_q[`UCPT_CFG_STOP2]};
                  end
               end else begin
                  txd <= txSh_q[0];
                  txSh_q <= txSh_q >> 1;
                  txCnt_q <= txCnt_q + 4'h1;
               end
            end
            ucpt_pkg::TX_PAR: begin
               txSt_q <= ucpt_pkg::TX_STOP;
               txd <= 1'b1;
               txCnt_q <= {3'h0, cfg_q[`UCPT_CFG_STOP2]};
            end
            ucpt_pkg::TX_STOP: begin
               txd <= 1'b1;
               if (txCnt_q != 4'h0) begin
                  txCnt_q <= txCnt_q - 4'h1;
               end else if (guard_q != '0) begin
                  txSt_q <= ucpt_pkg::TX_GUARD;
                  gCnt_q <= guard_q;
               end else begin
                  txSt_q <= ucpt_pkg::TX_IDLE;
               end
            end
            ucpt_pkg::TX_GUARD: begin
               txd <= 1'b1;
               gCnt_q <= gCnt_q - GUARD_W'(1);
               if (gCnt_q == GUARD_W'(1)) begin
                  txSt_q <= ucpt_pkg::TX_IDLE;
               end
            end
            default: txSt_q <= ucpt_pkg::TX_IDLE;
         endcase
      end
   end

endmodule

`default_nettype wire

/* File: bench/ucpt_serial_chk.sv */
// port assertions for the serial character block
`timescale 1ns/10ps
`default_nettype none
`include "ucpt_params.svh"
module ucpt_serial_chk #(
   parameter int DATA_BITS = 8,
   parameter int IDLE_W = 16,
   parameter int GUARD_W = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // serial line
   input wire logic bitClk,
   input wire logic rxd,
   input wire logic txd
);
   logic rdAcc;
   logic wrAcc;
   logic badAddr;
   logic [3:0] cfg_q;
   logic [IDLE_W-1:0] idle_q;
   logic [GUARD_W-1:0] guard_q;
   logic clkPrev_q;
   logic [7:0] fallAge_q;
   ////////////////////////////////////////////////////////////////////////////
   // access phase decode
   assign rdAcc = psel && penable && !pwrite;
   assign wrAcc = psel && penable && pwrite;
   assign badAddr = (paddr[1:0] != 2'h0) || (paddr > `UCPT_GUARD_OFS);
   // shadow copies of the read-write registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cfg_q <= `UCPT_CFG_RST;
         idle_q <= '0;
         guard_q <= '0;
      end else if (wrAcc) begin
         if (paddr == `UCPT_CFG_OFS) cfg_q <= pwdata[3:0];
         if (paddr == `UCPT_IDLE_OFS) idle_q <= pwdata[IDLE_W-1:0];
         if (paddr == `UCPT_GUARD_OFS) guard_q <= pwdata[GUARD_W-1:0];
      end
   end
   // mclk cycles since the last bit clock fall
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         clkPrev_q <= 1'b0;
         fallAge_q <= 8'hff;
      end else begin
         clkPrev_q <= bitClk;
         if (clkPrev_q && !bitClk) fallAge_q <= 8'h00;
         else if (fallAge_q != 8'hff) fallAge_q <= fallAge_q + 8'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_zero_wait: assert property (psel && penable |-> pready)
      else $error("pready low in access");
   a_map_err: assert property (psel && penable && badAddr |-> pslverr)
      else $error("no error on hole");
   a_map_ok: assert property (psel && penable && !badAddr |-> !pslverr)
      else $error("error on mapped");
   a_cfg_back: assert property (rdAcc && paddr == `UCPT_CFG_OFS |-> prdata == 32'(cfg_q))
      else $error("config readback");
   a_idle_back: assert property (rdAcc && paddr == `UCPT_IDLE_OFS |-> prdata == 32'(idle_q))
      else $error("limit readback");
   a_guard_back: assert property (rdAcc && paddr == `UCPT_GUARD_OFS |-> prdata == 32'(guard_q))
      else $error("guard readback");
   a_hole_zero: assert property (rdAcc && (badAddr || paddr == 8'h00) |-> prdata == 32'h0)
      else $error("hole reads nonzero");
   a_timeout_off: assert property (rdAcc && paddr == `UCPT_STAT_OFS && idle_q == '0
      |-> !prdata[5])
      else $error("timeout with zero limit");
   a_stat_width: assert property (rdAcc && paddr == `UCPT_STAT_OFS |-> prdata[31:6] == '0)
      else $error("status upper bits");
   a_rhr_width: assert property (rdAcc && paddr == `UCPT_RHR_OFS |-> prdata[31:8] == '0)
      else $error("holding upper bits");
   a_txd_fall: assert property ($changed(txd) |-> fallAge_q <= 8'h08)
      else $error("txd moved off bit fall");
endmodule
`default_nettype wire

/* File: bench/ucpt_remote.sv */
// remote serial partner: bit clock, character sender and receiver
`timescale 1ns/10ps
`default_nettype none
module ucpt_remote (
   // serial line
   output logic bitClk,
   output logic rxd,
   input wire logic txd
);
   // free running bit clock, 200 ns, phase unrelated to mclk
   initial begin
      bitClk = 1'b0;
      rxd = 1'b1;
      #3;
      forever #100 bitClk = ~bitClk;
   end
   // send one frame, changing the line on bit clock falls
   task automatic send_char(input logic [7:0] d, input logic hasPar, input logic p);
      int i;
      @(negedge bitClk);
      rxd <= 1'b0;
      for (i = 0; i < 8; i++) begin
         @(negedge bitClk);
         rxd <= d[i];
      end
      if (hasPar) begin
         @(negedge bitClk);
         rxd <= p;
      end
      @(negedge bitClk);
      rxd <= 1'b1;
      @(posedge bitClk);
   endtask
   // receive one frame on bit clock rises, counting idle samples first
   task automatic get_char(input logic hasPar, output logic [7:0] d, output logic p,
                           output int gap);
      int i;
      gap = 0;
      p = 1'b0;
      @(posedge bitClk);
      while (txd !== 1'b0 && gap < 400) begin
         gap++;
         @(posedge bitClk);
      end
      for (i = 0; i < 8; i++) begin
         @(posedge bitClk);
         d[i] = txd;
      end
      if (hasPar) begin
         @(posedge bitClk);
         p = txd;
      end
      @(posedge bitClk);
   endtask
   // wait a number of bit periods
   task automatic wait_bits(input int n);
      repeat (n) @(posedge bitClk);
   endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// testbench of the serial character block
`timescale 1ns/10ps
`default_nettype none
`include "ucpt_params.svh"
module tb;
   logic mclk, rstn, psel, penable, pwrite, pready, pslverr, bitClk, rxd, txd;
   logic errSeen, gotP, expP;
   logic [7:0] paddr, d, gotD;
   logic [31:0] pwdata, prdata, rdv;
   int badCount, checksDone, gap, i, g, n;
   ucpt_serial u_ucpt_serial (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bitClk(bitClk), .rxd(rxd), .txd(txd));
   ucpt_remote u_ucpt_remote (.bitClk(bitClk), .rxd(rxd), .txd(txd));
   // system clock 100 MHz
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   // comparison and verdict
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         badCount++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // one apb transfer; read data and error taken at the ready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && k < 20) begin
         k++;
         @(posedge mclk);
      end
      if (k >= 20) chk("pready", 32'h1, 32'(pready));
      rdv = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // parity bit the transmitter must send
   function automatic logic par_of(input logic [2:0] m, input logic [7:0] v);
      case (m)
         ucpt_pkg::PAR_EVEN: return ^v;
         ucpt_pkg::PAR_ODD: return ~^v;
         ucpt_pkg::PAR_MARK: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
   // watchdog
   initial begin
      #400000;
      chk("watchdog", 32'h0, 32'h1);
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      badCount = 0;
      checksDone = 0;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      apb(0, `UCPT_CFG_OFS, 0); chk("cfg reset", 32'h4, rdv);
      apb(0, `UCPT_IDLE_OFS, 0); chk("limit reset", 32'h0, rdv);
      apb(0, `UCPT_GUARD_OFS, 0); chk("guard reset", 32'h0, rdv);
      apb(0, `UCPT_STAT_OFS, 0); chk("status reset", 32'h12, rdv);
      apb(0, 8'h1c, 0); chk("hole error", 32'h1, 32'(errSeen));
      $display("test reset done");
      for (i = 0; i < 5; i++) begin
         d = 8'h41 + 8'(i);
         expP = par_of(3'(i), d);
         apb(1, `UCPT_CFG_OFS, i);
         apb(1, `UCPT_THR_OFS, 32'(d));
         u_ucpt_remote.get_char(i != 4, gotD, gotP, gap);
         chk("tx data", 32'(d), 32'(gotD));
         if (i != 4) chk("tx parity", 32'(expP), 32'(gotP));
         u_ucpt_remote.send_char(d, i != 4, expP);
         u_ucpt_remote.wait_bits(1);
         apb(0, `UCPT_RHR_OFS, 0); chk("rx data", 32'(d), rdv);
         apb(0, `UCPT_STAT_OFS, 0); chk("parity good", 32'h0, 32'(rdv[3]));
         u_ucpt_remote.send_char(d, i != 4, ~expP);
         u_ucpt_remote.wait_bits(1);
         apb(0, `UCPT_STAT_OFS, 0); chk("parity bad", 32'(i != 4), 32'(rdv[3]));
         apb(1, `UCPT_CMD_OFS, 32'h1);
         apb(0, `UCPT_STAT_OFS, 0); chk("parity clear", 32'h0, 32'(rdv[3]));
         apb(0, `UCPT_RHR_OFS, 0);
      end
      $display("test parity done");
      apb(1, `UCPT_CFG_OFS, 4);
      u_ucpt_remote.send_char(8'h11, 1'b0, 1'b0);
      u_ucpt_remote.send_char(8'h22, 1'b0, 1'b0);
      u_ucpt_remote.wait_bits(1);
      apb(0, `UCPT_STAT_OFS, 0); chk("overrun set", 32'h5, rdv & 32'h5);
      apb(0, `UCPT_RHR_OFS, 0); chk("overrun data", 32'h22, rdv);
      apb(0, `UCPT_STAT_OFS, 0); chk("ready cleared", 32'h4, rdv & 32'h5);
      apb(1, `UCPT_CMD_OFS, 32'h1);
      apb(0, `UCPT_STAT_OFS, 0); chk("overrun clear", 32'h0, rdv & 32'h5);
      $display("test overrun done");
      for (g = 6; g < 8; g++) begin
         apb(1, `UCPT_CFG_OFS, g);
         apb(1, `UCPT_THR_OFS, 32'h5a);
         u_ucpt_remote.get_char(1'b1, gotD, gotP, gap);
         chk("data mark", 32'h0, 32'(gotP));
         apb(1, `UCPT_CMD_OFS, 32'h2);
         apb(1, `UCPT_THR_OFS, 32'ha5);
         u_ucpt_remote.get_char(1'b1, gotD, gotP, gap);
         chk("addr mark", 32'h1, 32'(gotP));
         u_ucpt_remote.send_char(8'h33, 1'b1, 1'b1);
         u_ucpt_remote.wait_bits(1);
         apb(0, `UCPT_STAT_OFS, 0); chk("addr flag", 32'h1, 32'(rdv[3]));
         apb(1, `UCPT_CMD_OFS, 32'h1);
         u_ucpt_remote.send_char(8'h34, 1'b1, 1'b0);
         u_ucpt_remote.wait_bits(1);
         apb(0, `UCPT_STAT_OFS, 0); chk("data flag", 32'h0, 32'(rdv[3]));
         apb(0, `UCPT_RHR_OFS, 0); chk("md rx data", 32'h34, rdv);
      end
      $display("test multidrop done");
      for (g = 0; g < 4; g += 3) begin
         // second pass also sends two stop bits
         apb(1, `UCPT_CFG_OFS, (g == 3) ? 32'hc : 32'h4);
         apb(1, `UCPT_GUARD_OFS, g);
         apb(1, `UCPT_THR_OFS, 32'h81);
         // watch the first frame from its start while the second char queues behind it
         fork
            u_ucpt_remote.get_char(1'b0, gotD, gotP, gap);
            begin
               for (n = 0; n < 100; n++) begin
                  apb(0, `UCPT_STAT_OFS, 0);
                  if (rdv[1] === 1'b1) break;
               end
               apb(1, `UCPT_THR_OFS, 32'h7e);
            end
         join
         chk("first char", 32'h81, 32'(gotD));
         apb(0, `UCPT_STAT_OFS, 0); chk("guard flags", 32'h0, rdv & 32'h12);
         u_ucpt_remote.get_char(1'b0, gotD, gotP, gap);
         chk("guard gap", 32'(g + g / 3), 32'(gap));
         chk("second char", 32'h7e, 32'(gotD));
         u_ucpt_remote.wait_bits(g + 2);
         apb(0, `UCPT_STAT_OFS, 0); chk("all done", 32'h12, rdv & 32'h12);
      end
      $display("test guard done");
      apb(1, `UCPT_IDLE_OFS, 5);
      u_ucpt_remote.send_char(8'h01, 1'b0, 1'b0);
      u_ucpt_remote.wait_bits(3);
      apb(0, `UCPT_STAT_OFS, 0); chk("timeout early", 32'h0, 32'(rdv[5]));
      u_ucpt_remote.wait_bits(4);
      apb(0, `UCPT_STAT_OFS, 0); chk("timeout", 32'h1, 32'(rdv[5]));
      apb(1, `UCPT_CMD_OFS, 32'h4);
      u_ucpt_remote.wait_bits(10);
      apb(0, `UCPT_STAT_OFS, 0); chk("armed idle", 32'h0, 32'(rdv[5]));
      u_ucpt_remote.send_char(8'h02, 1'b0, 1'b0);
      u_ucpt_remote.wait_bits(7);
      apb(0, `UCPT_STAT_OFS, 0); chk("armed frame", 32'h1, 32'(rdv[5]));
      apb(1, `UCPT_CMD_OFS, 32'h8);
      u_ucpt_remote.wait_bits(3);
      apb(0, `UCPT_STAT_OFS, 0); chk("reload early", 32'h0, 32'(rdv[5]));
      u_ucpt_remote.wait_bits(4);
      apb(0, `UCPT_STAT_OFS, 0); chk("reload fire", 32'h1, 32'(rdv[5]));
      apb(1, `UCPT_IDLE_OFS, 0);
      u_ucpt_remote.wait_bits(8);
      apb(0, `UCPT_STAT_OFS, 0); chk("timeout off", 32'h0, 32'(rdv[5]));
      $display("test timeout done");
      conclude();
   end
endmodule
bind ucpt_serial ucpt_serial_chk #(.DATA_BITS(DATA_BITS), .IDLE_W(IDLE_W), .GUARD_W(GUARD_W))
   u_ucpt_serial_chk (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .bitClk(bitClk), .rxd(rxd), .txd(txd));
`default_nettype wire
